// ### rtl/mdms_device.sv
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
// Operation
// - Every line bit is timed by management clock
// - Without suppression, require 32 ones before frame
// - Suppression defaults off, enabled after override write
// - Start delimiter zero then one follows preamble
// - Opcode 10 reads, opcode 01 writes
// - Opcodes 00 and 11 ignored entirely
// - Respond only when PHY address matches
// - Five-bit register address selects register
// - Read turnaround: released, then driven low
// - Write turnaround driven one then zero by station
// - Sixteen data bits, most significant first
// - Read shifts selected register out per clock
// - Write stores sixteen bits into addressed register
// - Absent register reads return all ones
// - Absent register writes change nothing
// - Line released between transactions
// - Back-to-back frames accepted without idle bits
// - Override bit self-clears on next write to registers 0 to 3
// - Writes to read-only bits are blocked
// - Reset restores every register default
module mdms_device (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  mdms_if.device                 link,
  input  wire logic [4:0]        phyAddrStrap,
  output logic                   skipSyncOnesEnable,
  output logic [15:0]            ctrlWord
);
  typedef enum logic [2:0] {
    HUNT, SFD, CMD, TA1, TA2, DATA, SKIP
  } mdms_dev_state_t;

  // ==========================================================
  // State
  logic            mdcS1, mdcS2, mdcPrev, mdioS1, mdioS2;
  logic            next_mdcS1, next_mdcS2, next_mdcPrev;
  logic            next_mdioS1, next_mdioS2;
  mdms_dev_state_t state, next_state;
  logic [5:0]      onesCnt, next_onesCnt;
  logic [4:0]      bitCnt, next_bitCnt;
  logic [10:0]     cmdReg, next_cmdReg;
  logic [4:0]      regSel, next_regSel;
  logic            isRead, next_isRead;
  logic [15:0]     shiftReg, next_shiftReg;
  logic            outBit, next_outBit;
  logic            outEn, next_outEn;
  logic [15:0]     ctrlReg, next_ctrlReg;
  logic [15:0]     extReg, next_extReg;
  logic            skipEn, next_skipEn;
  logic            ovr, next_ovr;
  logic [4:0]      phyAddr, next_phyAddr;
  logic            strapDone, next_strapDone;

  // ==========================================================
  // Helpers
  logic            rise;
  logic            bitIn;
  logic [11:0]     cmdFull;
  logic [15:0]     wrWord;
  logic [15:0]     rdValue;

  assign rise    = mdcS2 & ~mdcPrev;
  assign bitIn   = mdioS2;
  assign cmdFull = {cmdReg, bitIn};
  assign wrWord  = {shiftReg[14:0], bitIn};

  always_comb begin
    case (regSel)
      mdms_pkg::REG_CTRL: rdValue = ctrlReg;
      mdms_pkg::REG_STAT: begin
        rdValue = mdms_pkg::STAT_RO;
        rdValue[mdms_pkg::SKIP_BIT] = skipEn;
      end
      mdms_pkg::REG_ID1: rdValue = mdms_pkg::ID1_VAL;
      mdms_pkg::REG_ID2: rdValue = mdms_pkg::ID2_VAL;
      mdms_pkg::REG_EXT: begin
        rdValue = extReg;
        rdValue[mdms_pkg::OVR_BIT] = ovr;
        rdValue[mdms_pkg::PHYAD_MSB:mdms_pkg::PHYAD_LSB] = phyAddr;
      end
      default: rdValue = mdms_pkg::ABSENT_VAL;
    endcase
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_mdcS1     = link.mdc;
    next_mdcS2     = mdcS1;
    next_mdcPrev   = mdcS2;
    next_mdioS1    = link.mdio;
    next_mdioS2    = mdioS1;
    next_state     = state;
    next_onesCnt   = onesCnt;
    next_bitCnt    = bitCnt;
    next_cmdReg    = cmdReg;
    next_regSel    = regSel;
    next_isRead    = isRead;
    next_shiftReg  = shiftReg;
    next_outBit    = outBit;
    next_outEn     = outEn;
    next_ctrlReg   = ctrlReg;
    next_extReg    = extReg;
    next_skipEn    = skipEn;
    next_ovr       = ovr;
    next_phyAddr   = phyAddr;
    next_strapDone = 1'b1;
    // Strap is caught by the first clock after reset release
    if (!strapDone) begin
      next_phyAddr = phyAddrStrap;
    end
    // Frame state moves only on a management clock rising edge
    if (rise) begin
      case (state)
        HUNT: begin
          next_outEn = 1'b0;
          if (bitIn) begin
            if (onesCnt != 6'(mdms_pkg::PRE_LEN)) begin
              next_onesCnt = onesCnt + 6'h01;
            end
          end else begin
            next_onesCnt = '0;
            // First zero of the delimiter
            if (onesCnt == 6'(mdms_pkg::PRE_LEN) || skipEn) begin
              next_state = SFD;
            end
          end
        end
        SFD: begin
          next_bitCnt = '0;
          next_state  = bitIn ? CMD : HUNT;
        end
        CMD: begin
          next_cmdReg = cmdFull[10:0];
          next_bitCnt = bitCnt + 5'h01;
          if (bitCnt == 5'(mdms_pkg::CMD_BITS - 1)) begin
            next_bitCnt = '0;
            next_regSel = cmdFull[4:0];
            next_isRead = (cmdFull[11:10] == mdms_pkg::OP_READ);
            if (cmdFull[11:10] != mdms_pkg::OP_READ &&
                cmdFull[11:10] != mdms_pkg::OP_WRITE) begin
              next_state = HUNT;
            end else if (cmdFull[9:5] != phyAddr) begin
              next_state = SKIP;
            end else begin
              next_state = TA1;
            end
          end
        end
        TA1: begin
          // Read: line stayed released, now drive a zero
          next_state  = TA2;
          next_outEn  = isRead;
          next_outBit = 1'b0;
        end
        TA2: begin
          next_state = DATA;
          next_bitCnt = '0;
          if (isRead) begin
            next_shiftReg = rdValue;
            next_outBit   = rdValue[mdms_pkg::DATA_W - 1];
          end
        end
        DATA: begin
          next_bitCnt = bitCnt + 5'h01;
          if (isRead) begin
            next_shiftReg = {shiftReg[14:0], 1'b0};
            next_outBit   = shiftReg[14];
          end else begin
            next_shiftReg = wrWord;
          end
          if (bitCnt == 5'(mdms_pkg::DATA_W - 1)) begin
            // Straight back to hunting so a new frame may follow
            next_state = HUNT;
            next_outEn = 1'b0;
            if (!isRead) begin
              case (regSel)
                mdms_pkg::REG_CTRL: begin
                  next_ctrlReg = wrWord;
                  next_ovr     = 1'b0;
                end
                mdms_pkg::REG_STAT: begin
                  // Only the suppression bit is writable, under override
                  if (ovr) begin
                    next_skipEn = wrWord[mdms_pkg::SKIP_BIT];
                  end
                  next_ovr = 1'b0;
                end
                mdms_pkg::REG_ID1, mdms_pkg::REG_ID2: begin
                  next_ovr = 1'b0;
                end
                mdms_pkg::REG_EXT: begin
                  // Address field bits read back the strap
                  next_extReg = wrWord;
                  next_ovr    = wrWord[mdms_pkg::OVR_BIT];
                end
                default: begin
                  next_ovr = ovr;
                end
              endcase
            end
          end
        end
        SKIP: begin
          // Foreign frame: ride out its turnaround and data
          next_bitCnt = bitCnt + 5'h01;
          if (bitCnt == 5'(mdms_pkg::SKIP_BITS - 1)) begin
            next_state = HUNT;
          end
        end
        default: begin
          next_state = HUNT;
          next_outEn = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mdcS1     <= 1'b0;
      mdcS2     <= 1'b0;
      mdcPrev   <= 1'b0;
      mdioS1    <= 1'b1;
      mdioS2    <= 1'b1;
      state     <= HUNT;
      onesCnt   <= '0;
      bitCnt    <= '0;
      cmdReg    <= '0;
      regSel    <= '0;
      isRead    <= 1'b0;
      shiftReg  <= '0;
      outBit    <= 1'b0;
      outEn     <= 1'b0;
      ctrlReg   <= mdms_pkg::CTRL_RST;
      extReg    <= mdms_pkg::EXT_RST;
      skipEn    <= 1'b0;
      ovr       <= 1'b0;
      phyAddr   <= '0;
      strapDone <= 1'b0;
    end else begin
      mdcS1     <= next_mdcS1;
      mdcS2     <= next_mdcS2;
      mdcPrev   <= next_mdcPrev;
      mdioS1    <= next_mdioS1;
      mdioS2    <= next_mdioS2;
      state     <= next_state;
      onesCnt   <= next_onesCnt;
      bitCnt    <= next_bitCnt;
      cmdReg    <= next_cmdReg;
      regSel    <= next_regSel;
      isRead    <= next_isRead;
      shiftReg  <= next_shiftReg;
      outBit    <= next_outBit;
      outEn     <= next_outEn;
      ctrlReg   <= next_ctrlReg;
      extReg    <= next_extReg;
      skipEn    <= next_skipEn;
      ovr       <= next_ovr;
      phyAddr   <= next_phyAddr;
      strapDone <= next_strapDone;
    end
  end

  assign link.mdioDevOut    = outBit;
  assign link.mdioDevOe     = outEn;
  assign skipSyncOnesEnable = skipEn;
  assign ctrlWord           = ctrlReg;
endmodule : mdms_device

// ### common/mdms_pkg.sv
package mdms_pkg;
  // ==========================================================
  // Frame layout
  localparam int          PRE_LEN    = 32;
  localparam int          DATA_W     = 16;
  localparam int          CMD_BITS   = 12;
  localparam int          SKIP_BITS  = 18;
  localparam int          FRAME_BITS = 64;
  localparam int          BODY_START = 32;
  localparam int          TA_END     = 46;
  localparam int          DATA_START = 48;
  localparam logic [1:0]  SFD_CODE   = 2'h1;
  localparam logic [1:0]  OP_READ    = 2'h2;
  localparam logic [1:0]  OP_WRITE   = 2'h1;
  localparam logic [1:0]  TA_WRITE   = 2'h2;
  // ==========================================================
  // Device register map
  localparam logic [4:0]  REG_CTRL   = 5'h00;
  localparam logic [4:0]  REG_STAT   = 5'h01;
  localparam logic [4:0]  REG_ID1    = 5'h02;
  localparam logic [4:0]  REG_ID2    = 5'h03;
  localparam logic [4:0]  REG_EXT    = 5'h10;
  localparam int          SKIP_BIT   = 6;
  localparam int          OVR_BIT    = 15;
  localparam int          PHYAD_LSB  = 6;
  localparam int          PHYAD_MSB  = 10;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] EXT_RST    = 16'h0000;
  localparam logic [15:0] STAT_RO    = 16'h0000;
  localparam logic [15:0] ABSENT_VAL = 16'hffff;
  // Identification values are arbitrary
  localparam logic [15:0] ID1_VAL    = 16'h1234;
  localparam logic [15:0] ID2_VAL    = 16'h5678;
  // ==========================================================
  // Station command registers
  localparam logic [7:0]  OFF_CMD    = 8'h00;
  localparam logic [7:0]  OFF_WDATA  = 8'h04;
  localparam logic [7:0]  OFF_STATUS = 8'h08;
  localparam logic [7:0]  OFF_RDATA  = 8'h0c;
  localparam int          CMD_RD_BIT = 0;
  localparam int          CMD_PHY_LSB = 1;
  localparam int          CMD_REG_LSB = 6;
  localparam int          CMD_SKIP_BIT = 11;
  // ==========================================================
  // Timing
  localparam int          CLK_NS      = 10;
  localparam int          MDC_HALF_NS = 80;
  localparam int          MDC_HALF    = MDC_HALF_NS / CLK_NS;
endpackage : mdms_pkg

// ### common/mdms_if.sv
`timescale 1ns/100ps
interface mdms_if;
  logic mdc;
  logic mdioStaOut;
  logic mdioStaOe;
  logic mdioDevOut;
  logic mdioDevOe;
  logic mdio;

  // Resolved line level; an undriven line floats high on its pull-up
  assign mdio = mdioDevOe ? mdioDevOut : (mdioStaOe ? mdioStaOut : 1'b1);

  modport device (
    input  mdc,
    input  mdio,
    output mdioDevOut,
    output mdioDevOe
  );
  modport station (
    output mdc,
    output mdioStaOut,
    output mdioStaOe,
    input  mdio
  );
endinterface : mdms_if

// ### rtl/mdms_station.sv
`timescale 1ns/100ps
module mdms_station (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  mdms_if.station                link,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wrData,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  output logic [31:0]            rdData,
  output logic                   busy
);
  typedef enum logic {IDLE, RUN} mdms_sta_state_t;

  mdms_sta_state_t state, next_state;
  logic [3:0]      phase, next_phase;
  logic [5:0]      bitIdx, next_bitIdx;
  logic [63:0]     frame, next_frame;
  logic            isRead, next_isRead;
  logic [15:0]     wData, next_wData;
  logic [15:0]     rWord, next_rWord;
  logic            mdcReg, next_mdcReg;
  logic            outBit, next_outBit;
  logic            outEn, next_outEn;
  logic [31:0]     rdReg, next_rdReg;
  logic            mdioS1, mdioS2, next_mdioS1, next_mdioS2;
  logic [1:0]      opCode;

  assign opCode = wrData[mdms_pkg::CMD_RD_BIT] ?
                  mdms_pkg::OP_READ : mdms_pkg::OP_WRITE;

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_state  = state;
    next_phase  = phase;
    next_bitIdx = bitIdx;
    next_frame  = frame;
    next_isRead = isRead;
    next_wData  = wData;
    next_rWord  = rWord;
    next_mdcReg = mdcReg;
    next_outBit = outBit;
    next_outEn  = outEn;
    next_rdReg  = '0;
    next_mdioS1 = link.mdio;
    next_mdioS2 = mdioS1;
    if (rdStb) begin
      case (addr)
        mdms_pkg::OFF_WDATA:  next_rdReg = {16'h0000, wData};
        mdms_pkg::OFF_STATUS: next_rdReg = {31'h00000000, state == RUN};
        mdms_pkg::OFF_RDATA:  next_rdReg = {16'h0000, rWord};
        default:              next_rdReg = '0;
      endcase
    end
    if (wrStb && addr == mdms_pkg::OFF_WDATA) begin
      next_wData = wrData[15:0];
    end
    case (state)
      IDLE: begin
        next_mdcReg = 1'b0;
        next_outEn  = 1'b0;
        // A command while busy is dropped
        if (wrStb && addr == mdms_pkg::OFF_CMD) begin
          next_state  = RUN;
          next_phase  = '0;
          next_isRead = wrData[mdms_pkg::CMD_RD_BIT];
          next_frame  = {32'hffffffff, mdms_pkg::SFD_CODE, opCode,
                         wrData[mdms_pkg::CMD_PHY_LSB +: 5],
                         wrData[mdms_pkg::CMD_REG_LSB +: 5],
                         mdms_pkg::TA_WRITE, wData};
          next_bitIdx = wrData[mdms_pkg::CMD_SKIP_BIT] ?
                        6'(mdms_pkg::BODY_START) : 6'h00;
        end
      end
      RUN: begin
        next_phase = phase + 4'h1;
        if (phase == 4'h0) begin
          // Drive the bit while the clock is low
          next_mdcReg = 1'b0;
          next_outBit = frame[6'(mdms_pkg::FRAME_BITS - 1) - bitIdx];
          next_outEn  = !isRead || bitIdx < 6'(mdms_pkg::TA_END);
        end else if (phase == 4'(mdms_pkg::MDC_HALF)) begin
          next_mdcReg = 1'b1;
          if (isRead && bitIdx >= 6'(mdms_pkg::DATA_START)) begin
            next_rWord = {rWord[14:0], mdioS2};
          end
        end else if (phase == 4'(2 * mdms_pkg::MDC_HALF - 1)) begin
          next_phase  = '0;
          next_bitIdx = bitIdx + 6'h01;
          if (bitIdx == 6'(mdms_pkg::FRAME_BITS - 1)) begin
            next_state = IDLE;
          end
        end
      end
      default: next_state = IDLE;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state  <= IDLE;
      phase  <= '0;
      bitIdx <= '0;
      frame  <= '0;
      isRead <= 1'b0;
      wData  <= '0;
      rWord  <= '0;
      mdcReg <= 1'b0;
      outBit <= 1'b0;
      outEn  <= 1'b0;
      rdReg  <= '0;
      mdioS1 <= 1'b1;
      mdioS2 <= 1'b1;
    end else begin
      state  <= next_state;
      phase  <= next_phase;
      bitIdx <= next_bitIdx;
      frame  <= next_frame;
      isRead <= next_isRead;
      wData  <= next_wData;
      rWord  <= next_rWord;
      mdcReg <= next_mdcReg;
      outBit <= next_outBit;
      outEn  <= next_outEn;
      rdReg  <= next_rdReg;
      mdioS1 <= next_mdioS1;
      mdioS2 <= next_mdioS2;
    end
  end

  assign link.mdc        = mdcReg;
  assign link.mdioStaOut = outBit;
  assign link.mdioStaOe  = outEn;
  assign rdData          = rdReg;
  assign busy            = (state == RUN);
endmodule : mdms_station

// ### dv/mdms_link_monitor.sv
`timescale 1ns/100ps
module mdms_link_monitor (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic mdc,
  input  wire logic mdioStaOut,
  input  wire logic mdioStaOe,
  input  wire logic mdioDevOut,
  input  wire logic mdioDevOe,
  input  wire logic mdio
);
  logic [15:0] oeLen;
  logic [15:0] next_oeLen;
  logic [7:0]  sinceRise;
  logic [7:0]  next_sinceRise;
  logic [7:0]  lowRun;
  logic [7:0]  next_lowRun;
  logic        mdcQ;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // ==========
  // Helper counters; sinceRise and lowRun saturate so long idles never wrap
  always_comb begin
    next_oeLen = mdioDevOe ? oeLen + 16'h1 : 16'h0;
    next_sinceRise = (mdc && !mdcQ) ? 8'h0 :
                     (sinceRise == 8'hff) ? sinceRise : sinceRise + 8'h1;
    next_lowRun = mdc ? 8'h0 :
                  (lowRun == 8'hff) ? lowRun : lowRun + 8'h1;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      oeLen <= 16'h0;
      sinceRise <= 8'hff;
      lowRun <= 8'h0;
      mdcQ <= 1'b0;
    end else begin
      oeLen <= next_oeLen;
      sinceRise <= next_sinceRise;
      lowRun <= next_lowRun;
      mdcQ <= mdc;
    end
  end

  // ==========
  // Link checks
  a_dev_edge_timed: assert property (
    $changed(mdioDevOe) || (mdioDevOe && $changed(mdioDevOut)) |->
      sinceRise >= 8'h1 && sinceRise <= 8'h7)
    else $error("device drive moved away from an mdc rise");
  a_no_contention: assert property (
    !(mdioDevOe && mdioStaOe))
    else $error("both ends drive the data line");
  a_ta_zero_first: assert property (
    $rose(mdioDevOe) |-> !mdioDevOut)
    else $error("first driven turnaround bit is not zero");
  a_ta_released: assert property (
    $rose(mdioDevOe) |-> !$past(mdioStaOe, 10))
    else $error("line not released during first turnaround bit");
  a_drive_span: assert property (
    $fell(mdioDevOe) |-> oeLen >= 16'd268 && oeLen <= 16'd276)
    else $error("device drive length is not seventeen bit times");
  a_mdc_half: assert property (
    $rose(mdc) |-> mdc [*8] ##1 !mdc)
    else $error("management clock high phase has wrong length");
  a_line_steady: assert property (
    $rose(mdc) |-> $stable(mdio))
    else $error("data line moved at the sampling edge");
  a_idle_released: assert property (
    lowRun > 8'd20 |-> !mdioDevOe)
    else $error("device drives an idle line");

  c_read_drive: cover property ($rose(mdioDevOe));
  c_long_idle: cover property (lowRun == 8'hff);
  c_mdc_rise: cover property ($rose(mdc));
endmodule : mdms_link_monitor

// ### dv/tb_mdio_management_slave.sv
`timescale 1ns/100ps
module tb_mdio_management_slave;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wrData = 32'h0;
  logic        wrStb = 1'b0;
  logic        rdStb = 1'b0;
  logic        rdSeen = 1'b0;
  logic [31:0] rdData;
  logic        busy;
  logic [4:0]  phyAddr = 5'h00;
  logic        skipEn;
  logic        skipEnB;
  logic [15:0] ctrlW;
  logic [15:0] ctrlWB;
  logic [15:0] expQ[$];
  int          bad_count = 0;
  int          n_checks = 0;

  mdms_if lnk ();
  mdms_if lnkB ();

  always #5 mclk = ~mclk;

  mdms_station u_mdms_station (.mclk(mclk), .arst_n(arst_n), .link(lnk),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .busy(busy));
  mdms_device u_mdms_device (.mclk(mclk), .arst_n(arst_n), .link(lnk),
    .phyAddrStrap(phyAddr), .skipSyncOnesEnable(skipEn), .ctrlWord(ctrlW));
  // Second device faces the bench's own rule-breaking driver
  mdms_device u_mdms_device_b (.mclk(mclk), .arst_n(arst_n), .link(lnkB),
    .phyAddrStrap(phyAddr), .skipSyncOnesEnable(skipEnB),
    .ctrlWord(ctrlWB));
  mdms_link_monitor u_mdms_link_monitor (.mclk(mclk), .arst_n(arst_n),
    .mdc(lnk.mdc), .mdioStaOut(lnk.mdioStaOut), .mdioStaOe(lnk.mdioStaOe),
    .mdioDevOut(lnk.mdioDevOut), .mdioDevOe(lnk.mdioDevOe),
    .mdio(lnk.mdio));

  // ==========
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge mclk) begin
    if (rdSeen) begin
      check(rdData[15:0], expQ.pop_front());
    end
    rdSeen <= rdStb;
  end

  // ==========
  // Register port and frame drivers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expQ.push_back(e);
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
  endtask : rd

  task automatic frame(input logic rdOp, input logic [4:0] phy,
                       input logic [4:0] rg, input logic [15:0] d,
                       input logic skip);
    int n;
    wr(mdms_pkg::OFF_WDATA, {16'h0, d});
    wr(mdms_pkg::OFF_CMD, {20'h0, skip, rg, phy, rdOp});
    n = 0;
    @(posedge mclk);
    check(16'(busy), 16'h1);
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 2000) bad_count++;
  endtask : frame

  task automatic rdReg(input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] e, input logic skip);
    frame(1'b1, phy, rg, 16'h0, skip);
    rd(mdms_pkg::OFF_RDATA, e);
  endtask : rdReg

  function automatic logic [63:0] mk(input logic [1:0] op,
      input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
    return {32'hffffffff, 2'b01, op, phy, rg, 2'b10, d};
  endfunction : mk

  // Bit-bangs one frame, releasing the line after nOe bits
  task automatic bb(input logic [63:0] v, input int nOe,
                    output logic [63:0] got, output logic drv);
    drv = 1'b0;
    got = 64'h0;
    for (int i = 63; i >= 0; i--) begin
      @(posedge mclk);
      lnkB.mdc <= 1'b0;
      lnkB.mdioStaOut <= v[i];
      lnkB.mdioStaOe <= (63 - i) < nOe;
      for (int c = 0; c < 15; c++) begin
        @(posedge mclk);
        drv |= lnkB.mdioDevOe;
        if (c == 7) begin
          got = {got[62:0], lnkB.mdio};
          lnkB.mdc <= 1'b1;
        end
      end
    end
    @(posedge mclk);
    lnkB.mdc <= 1'b0;
    lnkB.mdioStaOe <= 1'b0;
  endtask : bb

  // ==========
  // Main sequence
  initial begin
    logic [15:0] d;
    logic [63:0] got;
    logic        drv;
    lnkB.mdc = 1'b0;
    lnkB.mdioStaOut = 1'b0;
    lnkB.mdioStaOe = 1'b0;
    void'($urandom(32'h512bab33));
    phyAddr = 5'($urandom);
    d = 16'($urandom);
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(8'h10, 16'h0);
    rdReg(phyAddr, mdms_pkg::REG_CTRL, mdms_pkg::CTRL_RST, 1'b0);
    rdReg(phyAddr, mdms_pkg::REG_STAT, mdms_pkg::STAT_RO, 1'b0);
    rdReg(phyAddr, mdms_pkg::REG_ID1, mdms_pkg::ID1_VAL, 1'b0);
    rdReg(phyAddr, mdms_pkg::REG_ID2, mdms_pkg::ID2_VAL, 1'b0);
    frame(1'b0, phyAddr, mdms_pkg::REG_CTRL, d, 1'b0);
    check(ctrlW, d);
    rd(mdms_pkg::OFF_WDATA, d);
    rdReg(phyAddr, mdms_pkg::REG_CTRL, d, 1'b0);
    rdReg(phyAddr, 5'h1f, mdms_pkg::ABSENT_VAL, 1'b0);
    frame(1'b0, phyAddr, 5'h05, ~d, 1'b0);
    frame(1'b0, phyAddr ^ 5'h01, mdms_pkg::REG_CTRL, ~d, 1'b0);
    // A foreign read sees only the pull-up
    rdReg(phyAddr ^ 5'h01, mdms_pkg::REG_CTRL, 16'hffff, 1'b0);
    check(ctrlW, d);
    frame(1'b0, phyAddr, mdms_pkg::REG_STAT, 16'hffff, 1'b0);
    check(16'(skipEn), 16'h0);
    frame(1'b0, phyAddr, mdms_pkg::REG_EXT, 16'h8000, 1'b0);
    frame(1'b0, phyAddr, mdms_pkg::REG_STAT, 16'hffff, 1'b0);
    check(16'(skipEn), 16'h1);
    rdReg(phyAddr, mdms_pkg::REG_STAT,
          mdms_pkg::STAT_RO | (16'h1 << mdms_pkg::SKIP_BIT), 1'b1);
    // Override bit reads back cleared, address field shows the strap
    rdReg(phyAddr, mdms_pkg::REG_EXT,
          16'(phyAddr) << mdms_pkg::PHYAD_LSB, 1'b1);
    frame(1'b0, phyAddr, mdms_pkg::REG_STAT, 16'h0, 1'b0);
    check(16'(skipEn), 16'h1);
    arst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    check(16'(skipEn), 16'h0);
    check(ctrlW, mdms_pkg::CTRL_RST);
    bb(mk(mdms_pkg::OP_READ, phyAddr, mdms_pkg::REG_ID1, 16'h0)
       & 64'h7fffffffffffffff, 46, got, drv);
    check(16'(drv), 16'h0);
    // Broken start delimiter: zero then zero
    bb(mk(mdms_pkg::OP_READ, phyAddr, mdms_pkg::REG_ID1, 16'h0)
       & 64'hffffffffbfffffff, 46, got, drv);
    check(16'(drv), 16'h0);
    for (int k = 0; k < 4; k += 3) begin
      bb(mk(2'(k), phyAddr, mdms_pkg::REG_CTRL, 16'hffff), 64, got, drv);
      check(16'(drv), 16'h0);
      check(ctrlWB, 16'h0);
    end
    bb(mk(mdms_pkg::OP_READ, phyAddr ^ 5'h10, mdms_pkg::REG_ID1, 16'h0),
       46, got, drv);
    check(16'(drv), 16'h0);
    bb(mk(mdms_pkg::OP_WRITE, phyAddr, mdms_pkg::REG_CTRL, ~d), 64, got, drv);
    check(ctrlWB, ~d);
    repeat (2) begin
      bb(mk(mdms_pkg::OP_READ, phyAddr, mdms_pkg::REG_ID1, 16'h0),
         46, got, drv);
      check(got[15:0], mdms_pkg::ID1_VAL);
      check(16'(got[17:16]), 16'h2);
    end
    wrap_up();
  end

  initial begin
    #400000;
    bad_count++;
    wrap_up();
  end
endmodule : tb_mdio_management_slave
